// ### logic/ivt_pkg.sv
// package of the interrupt vector and trap block: offsets, fields, codes
// assumes a 32-bit axi4-lite register bus and 8-bit node control fields
package ivt_pkg;

  // ==========================================================================
  // register offsets (byte addresses)
  localparam logic [11:0] IVT_REG_CFG       = 12'h000;
  localparam logic [11:0] IVT_REG_TFR       = 12'h004;
  localparam logic [11:0] IVT_REG_TMASK     = 12'h008;
  localparam logic [11:0] IVT_REG_STAT      = 12'h00c;
  localparam logic [11:0] IVT_REG_NODE_BASE = 12'h040;

  // ==========================================================================
  // field positions and reset values
  localparam int          IVT_CFG_SEG_LSB  = 0;
  localparam int          IVT_CFG_SC_LSB   = 8;
  localparam logic [7:0]  IVT_SEG_RST      = 8'h00;
  localparam logic [1:0]  IVT_SC_RST       = 2'h0;
  localparam logic [4:0]  IVT_SC_SHIFT_MIN = 5'h02;
  localparam int          IVT_NODE_EN_BIT  = 6;
  localparam int          IVT_NODE_REQ_BIT = 7;
  localparam logic [7:0]  IVT_TMASK_RST    = 8'h00;
  localparam logic [1:0]  IVT_RESP_OKAY    = 2'h0;
  localparam logic [1:0]  IVT_RESP_SLVERR  = 2'h2;

  // ==========================================================================
  // trap causes: bits 0..3 class a (bit 0 highest), bits 4..7 class b
  localparam int          IVT_TRAPS       = 8;
  localparam int          IVT_TRAPS_A     = 4;
  localparam logic [6:0]  IVT_TNUM_A0     = 7'h02;
  localparam logic [6:0]  IVT_TNUM_STEP_A = 7'h02;
  localparam logic [6:0]  IVT_TNUM_B      = 7'h0a;
  localparam logic [3:0]  IVT_TRAP_LVL    = 4'hf;

  // service class codes as seen by the cpu
  localparam logic [1:0]  IVT_CLS_INT = 2'h0;
  localparam logic [1:0]  IVT_CLS_B   = 2'h1;
  localparam logic [1:0]  IVT_CLS_A   = 2'h2;

  typedef enum logic [2:0] {
    SVC_INT = 3'b001,
    SVC_TB  = 3'b010,
    SVC_TA  = 3'b100
  } ivt_svc_t;

  typedef struct packed {
    logic       req;
    logic       en;
    logic [3:0] prio;
  } ivt_node_ctrl_t;

  typedef struct packed {
    logic        is_trap;
    logic [1:0]  cls;
    logic [3:0]  lvl;
    logic [6:0]  num;
    logic [23:0] addr;
  } ivt_cpu_req_t;

endpackage

// ### logic/ivt_node.sv
// one interrupt node: request flag, enable flag, 4-bit priority
// assumes write strobe and data come from the register slave, same clock
`timescale 1ns/10ps
module ivt_node import ivt_pkg::*; (
  // clock and reset
  input  wire logic           clk_i,
  input  wire logic           srst_i,
  // register write
  input  wire logic           wr_i,
  input  wire logic [7:0]     wdata_i,
  // request set and clear
  input  wire logic           evt_i,
  input  wire logic           clr_i,
  // control state
  output ivt_node_ctrl_t      ctrl_o
);

  // ==========================================================================
  // control register
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ctrl_o.en   <= 1'b0;
      ctrl_o.prio <= 4'h0;
    end else if (wr_i) begin
      ctrl_o.en   <= wdata_i[IVT_NODE_EN_BIT];   // [RULE_08]
      ctrl_o.prio <= wdata_i[3:0];               // [RULE_09]
    end
  end

  // a peripheral event beats a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ctrl_o.req <= 1'b0;
    end else if (evt_i) begin
      ctrl_o.req <= 1'b1;
    end else if (wr_i) begin
      ctrl_o.req <= wdata_i[IVT_NODE_REQ_BIT];   // [RULE_11]
    end else if (clr_i) begin
      ctrl_o.req <= 1'b0;
    end
  end

  // ==========================================================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  node_sw_request_a: assert property ( // [RULE_11]
    wr_i && wdata_i[IVT_NODE_REQ_BIT] |=> ctrl_o.req)
    else $error("software request bit not set");
  node_prio_write_a: assert property ( // [RULE_09]
    wr_i |=> ctrl_o.prio == $past(wdata_i[3:0]))
    else $error("priority field not written");
  node_event_set_a: assert property ( // [RULE_08]
    evt_i |=> ctrl_o.req)
    else $error("peripheral event lost");

endmodule

// ### logic/ivt_arb.sv
// priority finder over the node requests: highest level, lowest index
// assumes eligible flags already include request and enable
`timescale 1ns/10ps
module ivt_arb #(
  parameter int N  = 8,
  parameter int IW = 3
) (
  // candidates
  input  wire logic [N-1:0]      elig_i,
  input  wire logic [N-1:0][3:0] prio_i,
  // winner
  output logic                   valid_o,
  output logic [IW-1:0]          idx_o,
  output logic [3:0]             lvl_o
);

  // ==========================================================================
  // linear scan; strict compare keeps the lowest index on equal levels
  always_comb begin
    valid_o = 1'b0;
    idx_o   = '0;
    lvl_o   = 4'h0;
    for (int i = 0; i < N; i++) begin
      if (elig_i[i] && (!valid_o || prio_i[i] > lvl_o)) begin
        valid_o = 1'b1;
        idx_o   = IW'(i);
        lvl_o   = prio_i[i];
      end
    end
  end

endmodule

// ### logic/ivt_top.sv
// interrupt vector generation and hardware trap arbitration
// assumes an axi4-lite master, same-clock event pulses and a cpu core
// that stacks the service class and level and hands them back on return
//
// Functional notes
// RULE_01: vectors lie in the segment chosen by vector_segment_select.
// RULE_02: vector_spacing_field sets the spacing; trap number times spacing.
// RULE_03: after reset the spacing is four bytes.
// RULE_04: a trap cause raises a non-maskable request to its own vector; the code gives the class b causes (bits 4..7) one shared vector.
// RULE_05: each trap sets its own bit in trap_flag_register.
// RULE_06: a trap waits only while a higher priority trap is in service; the code also holds it while a trap of its own class is in service.
// RULE_07: interrupts and transfers cannot pre-empt a running trap service.
// RULE_08: each node control register holds request, enable and priority.
// RULE_09: each node priority is programmable to one of sixteen levels.
// RULE_10: a running interrupt service is pre-empted only by higher priority.
// RULE_11: software writing a node request bit raises that node's request.
// RULE_12: trap flag bits stay set until software clears them.
`timescale 1ns/10ps
module ivt_top import ivt_pkg::*; #(
  parameter int         NODES          = 8,
  parameter logic [6:0] NODE_TRAP_BASE = 7'h10
) (
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              srst_i,
  // axi4-lite write
  input  wire logic [11:0]       s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // axi4-lite read
  input  wire logic [11:0]       s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // event sources
  input  wire logic [NODES-1:0]  periph_evt_i,
  input  wire logic [IVT_TRAPS-1:0] trap_evt_i,
  // cpu side
  output logic                   cpu_req_o,
  output ivt_cpu_req_t           cpu_req_info_o,
  input  wire logic              cpu_ack_i,
  input  wire logic              cpu_reti_i,
  input  wire logic [1:0]        cpu_ret_cls_i,
  input  wire logic [3:0]        cpu_ret_lvl_i,
  // interrupt
  output logic                   irq_o
);

  localparam int IW = (NODES > 1) ? $clog2(NODES) : 1;

  if (NODES < 1 || NODES > 32 || int'(NODE_TRAP_BASE) + NODES > 128) begin : g_bad
    $error("ivt_top: NODES or NODE_TRAP_BASE out of range");
  end

  // ==========================================================================
  // register state
  logic [7:0]            cfg_seg;
  logic [1:0]            cfg_sc;
  logic [IVT_TRAPS-1:0]  trap_flag_register;
  logic [IVT_TRAPS-1:0]  tmask;
  logic [IVT_TRAPS-1:0]  tfr_clr;
  logic [IVT_TRAPS-1:0]  trap_pend;
  ivt_svc_t              svc_cls;
  logic [3:0]            svc_lvl;
  logic [IVT_TRAPS-1:0]  sel_cause;
  logic [IW-1:0]         sel_idx;

  // ==========================================================================
  // axi write channel: address and data taken in either order
  logic        aw_held;
  logic        w_held;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        wr_fire;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign wr_fire       = aw_held && w_held;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 12'h000;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
    end
  end

  function automatic logic is_node(input logic [11:0] a);
    return a[11:2] >= IVT_REG_NODE_BASE[11:2] &&
           a[11:2] < IVT_REG_NODE_BASE[11:2] + 10'(NODES);
  endfunction

  function automatic logic is_mapped(input logic [11:0] a);
    return a[1:0] == 2'h0 &&
           (a == IVT_REG_CFG || a == IVT_REG_TFR || a == IVT_REG_TMASK ||
            a == IVT_REG_STAT || is_node(a));
  endfunction

  logic wr_cfg;
  logic wr_tfr;
  logic wr_tmask;
  logic [9:0] wr_node_idx;

  assign wr_cfg      = wr_fire && aw_addr == IVT_REG_CFG;
  assign wr_tfr      = wr_fire && aw_addr == IVT_REG_TFR && w_strb[0];
  assign wr_tmask    = wr_fire && aw_addr == IVT_REG_TMASK && w_strb[0];
  assign wr_node_idx = aw_addr[11:2] - IVT_REG_NODE_BASE[11:2];
  assign tfr_clr     = wr_tfr ? w_data[IVT_TRAPS-1:0] : '0;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= IVT_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= is_mapped(aw_addr) ? IVT_RESP_OKAY : IVT_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================================
  // configuration, flag and mask registers
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cfg_seg <= IVT_SEG_RST;
      cfg_sc  <= IVT_SC_RST;                                   // [RULE_03]
    end else if (wr_cfg) begin
      if (w_strb[0]) cfg_seg <= w_data[IVT_CFG_SEG_LSB +: 8];  // [RULE_01]
      if (w_strb[1]) cfg_sc  <= w_data[IVT_CFG_SC_LSB +: 2];   // [RULE_02]
    end
  end

  // a trap in the cycle of a clearing write keeps its flag
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      trap_flag_register <= '0;
    end else begin
      trap_flag_register <= (trap_flag_register & ~tfr_clr) | trap_evt_i;  // [RULE_05] [RULE_12]
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      tmask <= IVT_TMASK_RST;
    end else if (wr_tmask) begin
      tmask <= w_data[IVT_TRAPS-1:0];
    end
  end

  assign irq_o = |(trap_flag_register & tmask);

  // ==========================================================================
  // interrupt nodes and their arbiter
  ivt_node_ctrl_t [NODES-1:0] node;
  logic [NODES-1:0]           node_elig;
  logic [NODES-1:0][3:0]      node_prio;
  logic                       arb_valid;
  logic [IW-1:0]              arb_idx;
  logic [3:0]                 arb_lvl;
  logic                       ack;

  assign ack = cpu_req_o && cpu_ack_i;

  for (genvar i = 0; i < NODES; i++) begin : g_node
    ivt_node u_node (
      .clk_i   (clk_i),
      .srst_i  (srst_i),
      .wr_i    (wr_fire && w_strb[0] && aw_addr[1:0] == 2'h0 &&
                is_node(aw_addr) && wr_node_idx == 10'(i)),
      .wdata_i (w_data[7:0]),
      .evt_i   (periph_evt_i[i]),
      .clr_i   (ack && !cpu_req_info_o.is_trap && sel_idx == IW'(i)),
      .ctrl_o  (node[i])
    );
    assign node_elig[i] = node[i].req && node[i].en;
    assign node_prio[i] = node[i].prio;
  end

  ivt_arb #(
    .N  (NODES),
    .IW (IW)
  ) u_arb (
    .elig_i  (node_elig),
    .prio_i  (node_prio),
    .valid_o (arb_valid),
    .idx_o   (arb_idx),
    .lvl_o   (arb_lvl)
  );

  // ==========================================================================
  // trap pending: cleared when the cpu takes the trap, a new cause wins
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      trap_pend <= '0;
    end else if (ack && cpu_req_info_o.is_trap) begin
      trap_pend <= (trap_pend & ~sel_cause) | trap_evt_i;     // [RULE_04]
    end else begin
      trap_pend <= trap_pend | trap_evt_i;                    // [RULE_04]
    end
  end

  // ==========================================================================
  // selection of the next service
  logic                  cand_a;
  logic                  cand_b;
  logic [6:0]            num_a;
  logic [IVT_TRAPS-1:0]  cause_a;
  logic                  trap_ok;
  logic                  int_ok;
  logic                  sel_valid;
  ivt_cpu_req_t          next_info;
  logic [IVT_TRAPS-1:0]  next_cause;

  always_comb begin
    cand_a  = 1'b0;
    num_a   = IVT_TNUM_A0;
    cause_a = '0;
    for (int k = IVT_TRAPS_A - 1; k >= 0; k--) begin
      if (trap_pend[k]) begin
        cand_a  = 1'b1;
        num_a   = IVT_TNUM_A0 + 7'(k) * IVT_TNUM_STEP_A;
        cause_a = IVT_TRAPS'(1) << k;
      end
    end
  end

  assign cand_b  = |trap_pend[IVT_TRAPS-1:IVT_TRAPS_A];
  // class a waits for a class a service, class b for any trap service
  assign trap_ok = (cand_a && svc_cls != SVC_TA) ||
                   (cand_b && svc_cls == SVC_INT);                 // [RULE_06]
  assign int_ok  = svc_cls == SVC_INT && arb_valid &&  // [RULE_07]
                   arb_lvl > svc_lvl;                  // [RULE_10]
  assign sel_valid = trap_ok || int_ok;

  always_comb begin
    next_info  = '0;
    next_cause = '0;
    if (trap_ok) begin
      next_info.is_trap = 1'b1;
      next_info.lvl     = IVT_TRAP_LVL;
      if (cand_a && svc_cls != SVC_TA) begin
        next_info.cls = IVT_CLS_A;
        next_info.num = num_a;
        next_cause    = cause_a;
      end else begin
        // class b causes share one vector; the handler reads the flags
        next_info.cls = IVT_CLS_B;
        next_info.num = IVT_TNUM_B;
        next_cause    = {trap_pend[IVT_TRAPS-1:IVT_TRAPS_A], 4'h0};
      end
    end else begin
      next_info.cls = IVT_CLS_INT;
      next_info.lvl = arb_lvl;
      next_info.num = NODE_TRAP_BASE + 7'(arb_idx);
    end
    next_info.addr = {cfg_seg,  // [RULE_01] [RULE_02]
      16'(next_info.num) << (5'(cfg_sc) + IVT_SC_SHIFT_MIN)};
  end

  // request is dropped for one cycle after an accept so the cleared
  // source is not offered twice
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cpu_req_o      <= 1'b0;
      cpu_req_info_o <= '0;
      sel_cause      <= '0;
      sel_idx        <= '0;
    end else begin
      cpu_req_o      <= sel_valid && !ack;  // [RULE_04]
      cpu_req_info_o <= next_info;
      sel_cause      <= next_cause;
      sel_idx        <= arb_idx;
    end
  end

  // ==========================================================================
  // service state: class and level of what the cpu runs now
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      svc_cls <= SVC_INT;
      svc_lvl <= 4'h0;
    end else if (ack) begin
      svc_lvl <= cpu_req_info_o.lvl;
      case (cpu_req_info_o.cls)
        IVT_CLS_A: svc_cls <= SVC_TA;
        IVT_CLS_B: svc_cls <= SVC_TB;
        default:   svc_cls <= SVC_INT;
      endcase
    end else if (cpu_reti_i) begin
      svc_lvl <= cpu_ret_lvl_i;
      case (cpu_ret_cls_i)
        IVT_CLS_A: svc_cls <= SVC_TA;
        IVT_CLS_B: svc_cls <= SVC_TB;
        default:   svc_cls <= SVC_INT;
      endcase
    end
  end

  // ==========================================================================
  // axi read channel
  logic [31:0] rd_mux;
  logic [9:0]  rd_node_idx;

  assign s_axi_arready = !s_axi_rvalid;
  assign rd_node_idx   = s_axi_araddr[11:2] - IVT_REG_NODE_BASE[11:2];

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (s_axi_araddr == IVT_REG_CFG) begin
      rd_mux[IVT_CFG_SEG_LSB +: 8] = cfg_seg;
      rd_mux[IVT_CFG_SC_LSB +: 2]  = cfg_sc;
    end else if (s_axi_araddr == IVT_REG_TFR) begin
      rd_mux[IVT_TRAPS-1:0] = trap_flag_register;
    end else if (s_axi_araddr == IVT_REG_TMASK) begin
      rd_mux[IVT_TRAPS-1:0] = tmask;
    end else if (s_axi_araddr == IVT_REG_STAT) begin
      rd_mux = {8'h00, trap_pend, 1'b0, cpu_req_info_o.num, cpu_req_o,
                svc_cls, svc_lvl};
    end else if (s_axi_araddr[1:0] == 2'h0 && is_node(s_axi_araddr)) begin
      for (int i = 0; i < NODES; i++) begin
        if (rd_node_idx == 10'(i)) begin
          rd_mux[IVT_NODE_REQ_BIT] = node[i].req;
          rd_mux[IVT_NODE_EN_BIT]  = node[i].en;
          rd_mux[3:0]              = node[i].prio;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= IVT_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= is_mapped(s_axi_araddr) ? IVT_RESP_OKAY
                                              : IVT_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  sequence s_trap_waiting;
    trap_ok && !cpu_req_o && !cpu_reti_i;
  endsequence

  sequence s_accept;
    cpu_req_o && cpu_ack_i;
  endsequence

  vector_segment_a: assert property ( // [RULE_01]
    cpu_req_o && $stable(cfg_seg) |-> cpu_req_info_o.addr[23:16] == cfg_seg)
    else $error("vector outside selected segment");
  vector_spacing_a: assert property ( // [RULE_02]
    cpu_req_o && $stable(cfg_sc) |->
      cpu_req_info_o.addr[15:0] ==
        16'(cpu_req_info_o.num) * (16'h0004 << cfg_sc))
    else $error("vector offset not number times spacing");
  reset_spacing_a: assert property ( // [RULE_03]
    $past(srst_i) |-> cfg_sc == 2'h0 && cfg_seg == IVT_SEG_RST)
    else $error("spacing not four bytes after reset");
  trap_taken_a: assert property ( // [RULE_04]
    s_trap_waiting |=> cpu_req_o && cpu_req_info_o.is_trap)
    else $error("pending trap not offered next cycle");
  accept_drop_a: assert property ( // [RULE_04]
    s_accept |=> !cpu_req_o ##1 (svc_cls != SVC_INT || !$past(cpu_req_info_o.is_trap)))
    else $error("accepted request not withdrawn");
  flag_set_a: assert property ( // [RULE_05]
    |trap_evt_i |=> (trap_flag_register & $past(trap_evt_i)) == $past(trap_evt_i))
    else $error("trap flag not set");
  flag_sticky_a: assert property ( // [RULE_12]
    1'b1 |=> (($past(trap_flag_register) & ~$past(tfr_clr)) & ~trap_flag_register) == '0)
    else $error("trap flag dropped without clear");
  trap_wait_a: assert property ( // [RULE_06]
    svc_cls == SVC_TA && $stable(svc_cls) |->
      !(cpu_req_o && cpu_req_info_o.cls == IVT_CLS_A))
    else $error("class a trap pre-empted a class a service");
  int_blocked_a: assert property ( // [RULE_07]
    svc_cls != SVC_INT && $stable(svc_cls) |->
      !(cpu_req_o && !cpu_req_info_o.is_trap))
    else $error("interrupt offered during trap service");
  int_higher_a: assert property ( // [RULE_10]
    cpu_req_o && !cpu_req_info_o.is_trap && $stable(svc_lvl) &&
      $stable(svc_cls) |-> cpu_req_info_o.lvl > svc_lvl)
    else $error("interrupt not above current level");

endmodule

// ### dv/ivt_cpu_model.sv
// cpu core model: accepts offered services, stacks class and level
// assumes the bench pulses go_i and ret_i for one cycle, same clock
`timescale 1ns/10ps
module ivt_cpu_model import ivt_pkg::*; (
  // clock and reset
  input  wire logic          clk_i,
  input  wire logic          srst_i,
  // block side
  input  wire logic          req_i,
  input  wire ivt_cpu_req_t  info_i,
  output logic               ack_o,
  output logic               reti_o,
  output logic [5:0]         ret_o,
  // bench control
  input  wire logic          go_i,
  input  wire logic          ret_i
);
  logic [3:0][5:0] stk;
  logic [2:0]      sp;

  // ==========================================================================
  // accept and return
  // ack is dropped after one cycle, the block hides its offer after an ack
  always_ff @(posedge clk_i) begin
    ack_o  <= go_i && req_i && !ack_o;
    reti_o <= ret_i && sp != 3'h0;
    if (srst_i) begin
      sp     <= 3'h0;
      ack_o  <= 1'b0;
      reti_o <= 1'b0;
      ret_o  <= 6'h00;
    end else if (ack_o && req_i) begin
      stk[sp[1:0]] <= {info_i.cls, info_i.lvl};
      sp           <= sp + 3'h1;
    end else if (ret_i && sp != 3'h0) begin
      // outermost return restores plain program level
      ret_o <= (sp > 3'h1) ? stk[sp[1:0] - 2'h2] : 6'h00;
      sp    <= sp - 3'h1;
    end
  end
endmodule

// ### dv/ivt_tb.sv
// self-checking bench: register bus tasks, trap and interrupt sequences
// assumes the cpu model on the service side and a 50 MHz clock
`timescale 1ns/10ps
module interrupt_vector_and_trap_logic_tb_top import ivt_pkg::*;;
  localparam logic [1:0] OK = IVT_RESP_OKAY;
  localparam logic [1:0] ER = IVT_RESP_SLVERR;
  localparam logic [11:0] NB = IVT_REG_NODE_BASE;
  logic        clk_i, srst_i, awvalid, awready, wvalid, wready, bvalid;
  logic        bready, arvalid, arready, rvalid, rready;
  logic        req, ack, reti, irq, go, ret;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic [3:0]  wstrb;
  logic [7:0]  pevt, tevt;
  logic [5:0]  rets;
  ivt_cpu_req_t info;
  int          bad_count, tests_run;

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  ivt_top i_dut (.clk_i(clk_i), .srst_i(srst_i), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .periph_evt_i(pevt), .trap_evt_i(tevt),
    .cpu_req_o(req), .cpu_req_info_o(info), .cpu_ack_i(ack),
    .cpu_reti_i(reti), .cpu_ret_cls_i(rets[5:4]), .cpu_ret_lvl_i(rets[3:0]),
    .irq_o(irq));

  ivt_cpu_model i_cpu (.clk_i(clk_i), .srst_i(srst_i), .req_i(req),
    .info_i(info), .ack_o(ack), .reti_o(reti), .ret_o(rets), .go_i(go),
    .ret_i(ret));

  // ==========================================================================
  // checking and bus tasks
  task automatic chk(input string n, input logic [39:0] e, g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic conclude();
    if (bad_count == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ready is sampled at the falling edge, the transfer lands on the next rise
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic ta, tw, tb;
    logic [1:0] r;
    int n;
    n = 0;
    @(posedge clk_i);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(negedge clk_i);
      ta = awready;
      tw = wready;
      tb = bvalid;
      r  = bresp;
      @(posedge clk_i);
      n++;
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end while (!tb && n < 40);
    bready <= 1'b0;
    chk("bresp", {1'b1, er}, {tb, r});
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    logic ta, tb;
    logic [33:0] r;
    int n;
    n = 0;
    @(posedge clk_i);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(negedge clk_i);
      ta = arready;
      tb = rvalid;
      r  = {rresp, rdata};
      @(posedge clk_i);
      n++;
      if (ta) arvalid <= 1'b0;
    end while (!tb && n < 40);
    rready <= 1'b0;
    chk("rdata", {1'b1, er, ed}, {tb, r});
  endtask

  // ==========================================================================
  // service side tasks
  task automatic pulse(input logic [7:0] t, p);
    @(posedge clk_i);
    tevt <= t;
    pevt <= p;
    @(posedge clk_i);
    tevt <= 8'h00;
    pevt <= 8'h00;
  endtask

  task automatic offer(input logic [37:0] e);
    int n;
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (req !== 1'b1 && n < 20);
    chk("offer", {1'b1, e}, {req, info});
  endtask

  task automatic quiet();
    repeat (6) begin
      @(negedge clk_i);
      chk("idle", 40'h0, {39'h0, req});
    end
  endtask

  task automatic cpu(input logic acc);
    @(posedge clk_i);
    if (acc) go <= 1'b1;
    else ret <= 1'b1;
    @(posedge clk_i);
    go  <= 1'b0;
    ret <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask

  function automatic logic [37:0] ex(input logic [2:0] tc,
      input logic [3:0] l, input logic [6:0] num, input logic [7:0] seg,
      input logic [1:0] sc);
    return {tc, l, num, seg, {9'h000, num} << (5'd2 + sc)};
  endfunction

  initial begin
    repeat (5000) @(posedge clk_i);
    bad_count++;
    conclude();
  end

  // ==========================================================================
  // sequences
  initial begin
    srst_i = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready, go, ret} = '0;
    {awaddr, araddr, wdata, pevt, tevt} = '0;
    wstrb = 4'hf;
    {bad_count, tests_run} = '0;
    repeat (2) @(posedge clk_i);
    srst_i <= 1'b0;
    rd(IVT_REG_CFG, 32'h0, OK);
    rd(IVT_REG_TFR, 32'h0, OK);
    rd(12'h010, 32'h0, ER);
    wr(12'h002, 32'h1, ER);
    for (int p = 0; p < 16; p++) begin
      wr(NB, 32'(p), OK);
      rd(NB, 32'(p), OK);
    end
    wr(IVT_REG_TMASK, 32'hff, OK);
    wr(NB, 32'h43, OK);
    pulse(8'h02, 8'h00);
    offer(ex(3'b110, 4'hf, 7'h04, 8'h00, 2'h0));
    chk("irq", 40'h1, irq);
    cpu(1);
    pulse(8'h10, 8'h01);
    quiet();
    rd(IVT_REG_STAT, 32'h0010104f, OK);
    cpu(0);
    offer(ex(3'b101, 4'hf, 7'h0a, 8'h00, 2'h0));
    cpu(1);
    quiet();
    cpu(0);
    offer(ex(3'b000, 4'h3, 7'h10, 8'h00, 2'h0));
    cpu(1);
    cpu(0);
    rd(IVT_REG_TFR, 32'h12, OK);
    wr(IVT_REG_TFR, 32'h02, OK);
    rd(IVT_REG_TFR, 32'h10, OK);
    chk("irq", 40'h1, irq);
    wr(IVT_REG_TMASK, 32'h0f, OK);
    chk("irq", 40'h0, irq);
    wr(IVT_REG_TFR, 32'h10, OK);
    rd(IVT_REG_TFR, 32'h0, OK);
    wstrb <= 4'h1;
    wr(IVT_REG_CFG, 32'h312, OK);
    wstrb <= 4'hf;
    rd(IVT_REG_CFG, 32'h012, OK);
    wr(IVT_REG_CFG, 32'h112, OK);
    rd(IVT_REG_CFG, 32'h112, OK);
    wr(NB + 12'h00c, 32'hc5, OK);
    offer(ex(3'b000, 4'h5, 7'h13, 8'h12, 2'h1));
    cpu(1);
    wr(NB + 12'h008, 32'h45, OK);
    wr(NB + 12'h018, 32'h49, OK);
    pulse(8'h00, 8'h04);
    quiet();
    pulse(8'h00, 8'h40);
    offer(ex(3'b000, 4'h9, 7'h16, 8'h12, 2'h1));
    cpu(1);
    cpu(0);
    quiet();
    cpu(0);
    offer(ex(3'b000, 4'h5, 7'h12, 8'h12, 2'h1));
    cpu(1);
    cpu(0);
    conclude();
  end
endmodule
